// ==== src/buck_seq_pkg.sv ====
// Constants, command codes and carrier types for the buck sequencing control
package buck_seq_pkg;

  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF    = 8'h02;
  localparam logic [7:0] CMD_VOUT_SET  = 8'h21;
  localparam logic [7:0] CMD_UPPER     = 8'h24;
  localparam logic [7:0] CMD_LOWER     = 8'h28;
  localparam logic [7:0] CMD_SCALE     = 8'h29;
  localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD    = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD   = 8'h36;
  localparam logic [7:0] CMD_TON       = 8'h60;
  localparam logic [7:0] CMD_TOFF      = 8'h64;
  localparam logic [7:0] CMD_STATUS    = 8'h7A;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
  localparam logic [7:0] CMD_TRIM      = 8'hD4;
  localparam logic [7:0] CMD_MARGIN_HI = 8'hD5;
  localparam logic [7:0] CMD_MARGIN_LO = 8'hD6;

  // Field positions
  localparam int OP_ON_BIT     = 7;
  localparam int OP_MHI_BIT    = 5;
  localparam int OP_MLO_BIT    = 4;
  localparam int CFG_OP_BIT    = 3;
  localparam int CFG_PIN_BIT   = 2;
  localparam int CFG_POL_BIT   = 1;
  localparam int ST_UPPER_BIT  = 2;
  localparam int ST_LOWER_BIT  = 1;
  localparam int ST_INVALID_BIT = 0;

  // Loop scale encodings (unsigned, 9 fraction bits)
  localparam logic [15:0] SCALE_ONE     = 16'h0200;
  localparam logic [15:0] SCALE_HALF    = 16'h0100;
  localparam logic [15:0] SCALE_QUARTER = 16'h0080;

  // Valid commanded code ranges per scale
  localparam logic [15:0] VALID_MIN_1  = 16'h00B3;
  localparam logic [15:0] VALID_MAX_1  = 16'h034D;
  localparam logic [15:0] VALID_MIN_H  = 16'h0166;
  localparam logic [15:0] VALID_MAX_H  = 16'h069A;
  localparam logic [15:0] VALID_MIN_Q  = 16'h02CC;
  localparam logic [15:0] VALID_MAX_Q  = 16'h0B00;

  // Reference DAC limits, one code per 2^-9 V
  localparam logic [10:0] DAC_MIN = 11'h0B3;
  localparam logic [10:0] DAC_MAX = 11'h34D;

  // Input thresholds in quarter volts
  localparam logic [15:0] VIN_LO = 16'h0010;
  localparam logic [15:0] VIN_HI = 16'h001F;

  // Offset limits in DAC steps
  localparam logic signed [7:0] TRIM_MIN   = 8'shC0;
  localparam logic signed [7:0] TRIM_MAX   = 8'sh3F;
  localparam logic signed [7:0] MARGIN_MAX = 8'sh1F;

  // Reset values
  localparam logic [7:0]  RST_OPERATION = 8'h00;
  localparam logic [7:0]  RST_ON_OFF    = 8'h08;
  localparam logic [15:0] RST_VOUT      = 16'h0200;
  localparam logic [15:0] RST_UPPER     = 16'h034D;
  localparam logic [15:0] RST_LOWER     = 16'h00B3;
  localparam logic [15:0] RST_SCALE     = 16'h0200;
  localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD    = 16'h0012;
  localparam logic [15:0] RST_INPUT_TURN_OFF_THRESHOLD   = 16'h0010;
  localparam logic [15:0] RST_DELAY     = 16'h0000;

  // Timing
  localparam logic [15:0] DELAY_MAX_MS  = 16'h0064;
  localparam int          MS_PERIOD_NS  = 1000000;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CYCLES_PER_MS = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          AVG_LOG2      = 3;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_t;

endpackage

// ==== src/sense_avg.sv ====
// Block averager for output voltage telemetry samples
`timescale 1ns/1ps
`default_nettype none
module sense_avg #(
  parameter int W     = 16,
  parameter int LOG2N = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Samples in
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample,
  // Average out
  output logic      [W-1:0] avg
);
  logic [W+LOG2N-1:0] sum_reg;
  logic [LOG2N-1:0]   cnt_reg;
  logic [W+LOG2N-1:0] sum_next;
  logic               last;

  assign sum_next = sum_reg + {{LOG2N{1'b0}}, sample};
  assign last     = (cnt_reg == {LOG2N{1'b1}});

  // Power-of-two count keeps the divide a plain shift
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sum_reg <= '0;
      cnt_reg <= '0;
      avg     <= '0;
    end else if (sample_valid) begin
      cnt_reg <= cnt_reg + 1'b1;
      sum_reg <= last ? '0 : sum_next;
      if (last) begin
        avg <= sum_next[W+LOG2N-1:LOG2N];
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/buck_seq_ctrl.sv ====
// Sequencing, lockout, reference code and telemetry control of a buck converter
//
// Behaviour
// - Separate input turn-on and turn-off thresholds form the lockout hysteresis.
// - Thresholds held between 4 V turn-off floor and 7.75 V turn-on ceiling.
// - On/off config picks lockout only, plus control pin, plus operation bit.
// - After gating goes true, wait the turn-on delay before regulating.
// - After gating goes false, wait the turn-off delay before stopping.
// - Delays count in milliseconds, 0 to 100 ms.
// - Operation bit 7 turns conversion on or off when selected.
// - Reference DAC spans 350 mV to 1650 mV in 2^-9 V steps.
// - Sense voltage samples are averaged and kept as readable telemetry.
// - Loop scale maps commanded voltage to the feedback reference.
// - Commanded codes are valid only inside the range for the scale.
// - A commanded value beyond the limits is replaced by the violated limit.
// - Clamping sets the upper or lower limit status bit.
// - Trim is a signed offset of -64 to +63 steps.
// - Reference is scaled command plus trim and margin, held in DAC range.
`timescale 1ns/1ps
`default_nettype none
module buck_seq_ctrl #(
  parameter int CYCLES_MS = buck_seq_pkg::CYCLES_PER_MS,
  parameter int AVG_N_LOG = buck_seq_pkg::AVG_LOG2
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Decoded command writes and reads
  input  wire logic               cmd_valid,
  input  wire buck_seq_pkg::cmd_t cmd,
  input  wire logic [7:0]         rd_code,
  output logic      [15:0]        rd_data,
  // Converter side
  input  wire logic [15:0]        vin_meas,
  input  wire logic               control_pin,
  input  wire logic               sense_valid,
  input  wire logic [15:0]        remote_sense_output,
  output logic                    regulate_en,
  output logic      [10:0]        error_amp_reference,
  output logic      [2:0]         status_flags
);
  import buck_seq_pkg::*;

  typedef enum logic [3:0] {
    S_OFF      = 4'b0001,
    S_ON_WAIT  = 4'b0010,
    S_RUN      = 4'b0100,
    S_OFF_WAIT = 4'b1000
  } seq_state_t;

  localparam int TW = $clog2(CYCLES_MS + 1);

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [7:0] sat8(input logic [15:0] v,
                                            input logic signed [7:0] hi);
    logic signed [15:0] s;
    s = signed'(v);
    if (s < 16'(signed'(TRIM_MIN))) sat8 = TRIM_MIN;
    else if (s > 16'(signed'(hi))) sat8 = hi;
    else sat8 = s[7:0];
  endfunction

  // Command registers
  logic [7:0]         operation_reg;
  logic [7:0]         on_off_reg;
  logic [15:0]        vout_reg;
  logic [15:0]        output_upper_limit_reg;
  logic [15:0]        output_lower_limit_reg;
  logic [15:0]        output_feedback_scale_reg;
  logic [15:0]        input_turn_on_threshold_reg;
  logic [15:0]        input_turn_off_threshold_reg;
  logic [15:0]        ton_reg;
  logic [15:0]        toff_reg;
  logic signed [7:0]  trim_reg;
  logic signed [7:0]  margin_hi_reg;
  logic signed [7:0]  margin_lo_reg;
  logic [2:0]         status_reg;
  logic [2:0]         status_next;

  // Write decode
  logic wr_op, wr_cfg, wr_vout, wr_up, wr_lo, wr_scale, wr_von, wr_voff;
  logic wr_ton, wr_toff, wr_trim, wr_mhi, wr_mlo, wr_status, scale_ok;
  assign wr_op     = cmd_valid && (cmd.code == CMD_OPERATION);
  assign wr_cfg    = cmd_valid && (cmd.code == CMD_ON_OFF);
  assign wr_vout   = cmd_valid && (cmd.code == CMD_VOUT_SET);
  assign wr_up     = cmd_valid && (cmd.code == CMD_UPPER);
  assign wr_lo     = cmd_valid && (cmd.code == CMD_LOWER);
  assign wr_scale  = cmd_valid && (cmd.code == CMD_SCALE);
  assign wr_von    = cmd_valid && (cmd.code == CMD_INPUT_TURN_ON_THRESHOLD);
  assign wr_voff   = cmd_valid && (cmd.code == CMD_INPUT_TURN_OFF_THRESHOLD);
  assign wr_ton    = cmd_valid && (cmd.code == CMD_TON);
  assign wr_toff   = cmd_valid && (cmd.code == CMD_TOFF);
  assign wr_trim   = cmd_valid && (cmd.code == CMD_TRIM);
  assign wr_mhi    = cmd_valid && (cmd.code == CMD_MARGIN_HI);
  assign wr_mlo    = cmd_valid && (cmd.code == CMD_MARGIN_LO);
  assign wr_status = cmd_valid && (cmd.code == CMD_STATUS);
  // Only three divider ratios exist; other codes are dropped
  assign scale_ok  = (cmd.data == SCALE_ONE) || (cmd.data == SCALE_HALF) ||
                     (cmd.data == SCALE_QUARTER);

  // Commanded voltage clamp against limits
  logic        over_up, under_lo;
  logic [15:0] vout_next;
  assign over_up   = cmd.data > output_upper_limit_reg;
  assign under_lo  = cmd.data < output_lower_limit_reg;
  assign vout_next = over_up ? output_upper_limit_reg :
                     (under_lo ? output_lower_limit_reg : cmd.data);

  // Valid range for the present scale
  logic [1:0]  shift;
  logic [15:0] valid_min, valid_max;
  logic        vout_invalid;
  assign shift = (output_feedback_scale_reg == SCALE_QUARTER) ? 2'd2 :
                 ((output_feedback_scale_reg == SCALE_HALF) ? 2'd1 : 2'd0);
  assign valid_min = (shift == 2'd2) ? VALID_MIN_Q : ((shift == 2'd1) ? VALID_MIN_H : VALID_MIN_1);
  assign valid_max = (shift == 2'd2) ? VALID_MAX_Q : ((shift == 2'd1) ? VALID_MAX_H : VALID_MAX_1);
  assign vout_invalid = (vout_reg < valid_min) || (vout_reg > valid_max);

  // Sticky limit status bits, an event wins over a clear in the same cycle; the invalid bit follows vout_reg
  assign status_next[ST_UPPER_BIT] = (wr_vout && over_up) ||
                      (status_reg[ST_UPPER_BIT] && !(wr_status && cmd.data[ST_UPPER_BIT]));
  assign status_next[ST_LOWER_BIT] = (wr_vout && !over_up && under_lo) ||
                      (status_reg[ST_LOWER_BIT] && !(wr_status && cmd.data[ST_LOWER_BIT]));
  assign status_next[ST_INVALID_BIT] = vout_invalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operation_reg <= RST_OPERATION;
      on_off_reg    <= RST_ON_OFF;
      vout_reg      <= RST_VOUT;
      status_reg    <= '0;
    end else begin
      if (wr_op) operation_reg <= cmd.data[7:0];
      if (wr_cfg) on_off_reg <= cmd.data[7:0];
      if (wr_vout) vout_reg <= vout_next;
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_upper_limit_reg    <= RST_UPPER;
      output_lower_limit_reg    <= RST_LOWER;
      output_feedback_scale_reg <= RST_SCALE;
    end else begin
      if (wr_up) output_upper_limit_reg <= cmd.data;
      if (wr_lo) output_lower_limit_reg <= cmd.data;
      if (wr_scale && scale_ok) output_feedback_scale_reg <= cmd.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      input_turn_on_threshold_reg  <= RST_INPUT_TURN_ON_THRESHOLD;
      input_turn_off_threshold_reg <= RST_INPUT_TURN_OFF_THRESHOLD;
      ton_reg                      <= RST_DELAY;
      toff_reg                     <= RST_DELAY;
    end else begin
      if (wr_von) input_turn_on_threshold_reg <= clamp16(cmd.data, VIN_LO, VIN_HI);
      if (wr_voff) input_turn_off_threshold_reg <= clamp16(cmd.data, VIN_LO, VIN_HI);
      if (wr_ton) ton_reg <= clamp16(cmd.data, 16'h0000, DELAY_MAX_MS);
      if (wr_toff) toff_reg <= clamp16(cmd.data, 16'h0000, DELAY_MAX_MS);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trim_reg      <= '0;
      margin_hi_reg <= '0;
      margin_lo_reg <= '0;
    end else begin
      if (wr_trim) trim_reg <= sat8(cmd.data, TRIM_MAX);
      if (wr_mhi) margin_hi_reg <= sat8(cmd.data, MARGIN_MAX);
      if (wr_mlo) margin_lo_reg <= sat8(cmd.data, MARGIN_MAX);
    end
  end

  // Lockout with hysteresis
  logic uvlo_ok_reg;
  logic uvlo_ok_next;
  assign uvlo_ok_next = uvlo_ok_reg ? (vin_meas >= input_turn_off_threshold_reg) :
                                      (vin_meas >= input_turn_on_threshold_reg);

  // Start gating
  logic pin_active, op_ok, pin_ok, gate;
  assign pin_active = (control_pin == on_off_reg[CFG_POL_BIT]);
  assign op_ok  = !on_off_reg[CFG_OP_BIT] || operation_reg[OP_ON_BIT];
  assign pin_ok = !on_off_reg[CFG_PIN_BIT] || pin_active;
  assign gate   = uvlo_ok_reg && op_ok && pin_ok;

  // Millisecond timer, restarted on every state change
  seq_state_t     state_reg, state_next;
  logic [TW-1:0]  tick_reg;
  logic [6:0]     ms_reg;
  logic           tick, timer_clr, ton_done, toff_done;
  assign tick      = (tick_reg == TW'(CYCLES_MS - 1));
  assign timer_clr = (state_next != state_reg);
  assign ton_done  = (ms_reg == ton_reg[6:0]);
  assign toff_done = (ms_reg == toff_reg[6:0]);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_OFF: begin
        if (gate) state_next = (ton_reg == 16'h0000) ? S_RUN : S_ON_WAIT;
      end
      S_ON_WAIT: begin
        if (!gate) state_next = S_OFF;
        else if (ton_done) state_next = S_RUN;
      end
      S_RUN: begin
        if (!gate) state_next = (toff_reg == 16'h0000) ? S_OFF : S_OFF_WAIT;
      end
      S_OFF_WAIT: begin
        if (gate) state_next = S_RUN;
        else if (toff_done) state_next = S_OFF;
      end
      default: state_next = S_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= S_OFF;
      uvlo_ok_reg <= 1'b0;
      regulate_en <= 1'b0;
    end else begin
      state_reg   <= state_next;
      uvlo_ok_reg <= uvlo_ok_next;
      regulate_en <= (state_next == S_RUN) || (state_next == S_OFF_WAIT);
    end
  end

  // Counters run from the state change, so a delay is whole milliseconds
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_reg <= '0;
      ms_reg   <= '0;
    end else if (timer_clr) begin
      tick_reg <= '0;
      ms_reg   <= '0;
    end else begin
      tick_reg <= tick ? '0 : tick_reg + 1'b1;
      if (tick && ms_reg != 7'h7F) ms_reg <= ms_reg + 1'b1;
    end
  end

  // Reference code
  logic signed [17:0] scaled, offs, ref_sum;
  logic [10:0]        ref_next;
  assign scaled = signed'({2'b00, vout_reg >> shift});
  assign offs = 18'(trim_reg) +
                (operation_reg[OP_MHI_BIT] ? 18'(margin_hi_reg) : 18'sd0) +
                (operation_reg[OP_MLO_BIT] ? 18'(margin_lo_reg) : 18'sd0);
  assign ref_sum  = scaled + offs;
  // Limits compared as signed so a negative sum clamps low, not high
  assign ref_next = (ref_sum < signed'(18'(DAC_MIN))) ? DAC_MIN :
                    ((ref_sum > signed'(18'(DAC_MAX))) ? DAC_MAX : ref_sum[10:0]);

  // Telemetry
  logic [15:0] read_vout;
  sense_avg #(
    .W     (16),
    .LOG2N (AVG_N_LOG)
  ) u_avg (
    .clk          (clk),
    .nrst         (nrst),
    .sample_valid (sense_valid),
    .sample       (remote_sense_output),
    .avg          (read_vout)
  );

  // Read mux
  logic [15:0] rd_next;
  always_comb begin
    rd_next = 16'h0000;
    case (rd_code)
      CMD_OPERATION: rd_next = {8'h00, operation_reg};
      CMD_ON_OFF:    rd_next = {8'h00, on_off_reg};
      CMD_VOUT_SET:  rd_next = vout_reg;
      CMD_UPPER:     rd_next = output_upper_limit_reg;
      CMD_LOWER:     rd_next = output_lower_limit_reg;
      CMD_SCALE:     rd_next = output_feedback_scale_reg;
      CMD_INPUT_TURN_ON_THRESHOLD:    rd_next = input_turn_on_threshold_reg;
      CMD_INPUT_TURN_OFF_THRESHOLD:   rd_next = input_turn_off_threshold_reg;
      CMD_TON:       rd_next = ton_reg;
      CMD_TOFF:      rd_next = toff_reg;
      CMD_STATUS:    rd_next = {13'h0000, status_reg};
      CMD_READ_VOUT: rd_next = read_vout;
      CMD_TRIM:      rd_next = 16'(trim_reg);
      CMD_MARGIN_HI: rd_next = 16'(margin_hi_reg);
      CMD_MARGIN_LO: rd_next = 16'(margin_lo_reg);
      default:       rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data             <= '0;
      error_amp_reference <= DAC_MIN;
      status_flags        <= '0;
    end else begin
      rd_data             <= rd_next;
      error_amp_reference <= ref_next;
      status_flags        <= status_next;
    end
  end

  // Checks
  a_uvlo_rise_thr: assert property (@(posedge clk) disable iff (!nrst)
    $rose(uvlo_ok_reg) |-> $past(vin_meas) >= $past(input_turn_on_threshold_reg))
    else $error("lockout released below turn-on threshold");
  a_thr_span: assert property (@(posedge clk) disable iff (!nrst)
    input_turn_on_threshold_reg <= VIN_HI && input_turn_off_threshold_reg >= VIN_LO)
    else $error("input threshold outside span");
  a_ton_wait: assert property (@(posedge clk) disable iff (!nrst)
    $rose(regulate_en) && $past(ton_reg) != 16'h0000 |->
      $past(state_reg) == S_ON_WAIT && $past(ms_reg) == $past(ton_reg[6:0]))
    else $error("regulation began before turn-on delay");
  a_toff_wait: assert property (@(posedge clk) disable iff (!nrst)
    $fell(regulate_en) && $past(toff_reg) != 16'h0000 |->
      $past(state_reg) == S_OFF_WAIT && $past(ms_reg) == $past(toff_reg[6:0]))
    else $error("regulation stopped before turn-off delay");
  a_delay_cap: assert property (@(posedge clk) disable iff (!nrst)
    ton_reg <= DELAY_MAX_MS && toff_reg <= DELAY_MAX_MS)
    else $error("delay beyond 100 ms");
  a_op_bit_off: assert property (@(posedge clk) disable iff (!nrst)
    on_off_reg[CFG_OP_BIT] && !operation_reg[OP_ON_BIT] && state_reg == S_RUN |=>
      state_reg != S_RUN)
    else $error("operation off did not leave run");
  a_dac_range: assert property (@(posedge clk) disable iff (!nrst)
    error_amp_reference >= DAC_MIN && error_amp_reference <= DAC_MAX)
    else $error("reference outside DAC range");
  a_clamp_upper: assert property (@(posedge clk) disable iff (!nrst)
    wr_vout && over_up |=> vout_reg == $past(output_upper_limit_reg) &&
      status_reg[ST_UPPER_BIT])
    else $error("upper clamp or flag missing");
  a_clamp_lower: assert property (@(posedge clk) disable iff (!nrst)
    wr_vout && !over_up && under_lo |=> vout_reg == $past(output_lower_limit_reg) ##0
      status_reg[ST_LOWER_BIT])
    else $error("lower clamp or flag missing");
  a_trim_span: assert property (@(posedge clk) disable iff (!nrst)
    trim_reg >= TRIM_MIN && trim_reg <= TRIM_MAX)
    else $error("trim outside span");
  a_any_false: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == S_ON_WAIT && !gate |=> state_reg == S_OFF ##1 !regulate_en)
    else $error("pending start kept after a source dropped");
endmodule
`default_nettype wire

// ==== testbench/pmbus_host_model.sv ====
// Command-writing host model for the buck sequencing control
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  // Clock
  input  wire logic               clk,
  // Command side
  output logic                    cmd_valid,
  output buck_seq_pkg::cmd_t      cmd,
  output logic      [7:0]         rd_code,
  input  wire logic [15:0]        rd_data
);
  import buck_seq_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    rd_code = 8'h00;
  end
  // Callers keep commanded codes inside the range for the scale, except on purpose
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{code: c, data: d};
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd; // Released bus never shows a stale word
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    #1;
    rd_code = c;
    @(posedge clk);
    #1;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ==== testbench/buck_output_sequencing_control_bench.sv ====
// Self-checking bench for the buck sequencing control
`timescale 1ns/1ps
`default_nettype none
module buck_output_sequencing_control_bench;
  import buck_seq_pkg::*;
  localparam int MS = 20;
  logic clk, nrst, cmd_valid, control_pin, sense_valid, regulate_en;
  logic [7:0] rd_code;
  logic [15:0] rd_data, vin_meas, remote_sense_output, d;
  logic [10:0] error_amp_reference;
  logic [2:0] status_flags;
  cmd_t cmd;
  int n_errors, n_tests, n;
  buck_seq_ctrl #(.CYCLES_MS(MS), .AVG_N_LOG(3)) u_dut (.clk(clk), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rd_code(rd_code), .rd_data(rd_data),
    .vin_meas(vin_meas), .control_pin(control_pin), .sense_valid(sense_valid),
    .remote_sense_output(remote_sense_output), .regulate_en(regulate_en),
    .error_amp_reference(error_amp_reference), .status_flags(status_flags));
  pmbus_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .rd_code(rd_code), .rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Cycles until regulate_en reaches e; a bound that runs out ends the run
  task automatic wait_reg(input logic e, input int lim);
    for (n = 0; n < lim && regulate_en !== e; n++) begin
      @(posedge clk);
      #1;
    end
    if (regulate_en !== e) begin
      chk({15'h0000, regulate_en}, {15'h0000, e});
      wrap_up();
    end
  endtask
  task automatic ref_is(input logic [10:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, error_amp_reference}, {5'h00, e});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk({5'h00, error_amp_reference}, 16'h00B3);
    u_host.rd(CMD_UPPER, d);
    chk(d, 16'h034D);
    u_host.rd(8'h03, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_vout();
    u_host.wr(CMD_VOUT_SET, 16'h0400);
    ref_is(11'h34D);
    chk({13'h0000, status_flags}, 16'h0004);
    u_host.wr(CMD_STATUS, 16'h0006);
    u_host.wr(CMD_VOUT_SET, 16'h0010);
    ref_is(11'h0B3);
    chk({13'h0000, status_flags[2:1]}, 16'h0001);
    u_host.wr(CMD_UPPER, 16'h0B00);
    u_host.wr(CMD_SCALE, 16'h0100);
    u_host.wr(CMD_SCALE, 16'h0300);
    u_host.rd(CMD_SCALE, d);
    chk(d, 16'h0100);
    u_host.wr(CMD_VOUT_SET, 16'h0400);
    ref_is(11'h200);
    u_host.wr(CMD_TRIM, 16'hFFC0);
    ref_is(11'h1C0);
    u_host.wr(CMD_LOWER, 16'h0000);
    u_host.wr(CMD_VOUT_SET, 16'h0010);
    ref_is(11'h0B3);
    u_host.wr(CMD_TRIM, 16'h0050);
    u_host.rd(CMD_TRIM, d);
    chk(d, 16'h003F);
    u_host.wr(CMD_SCALE, 16'h0080);
    u_host.wr(CMD_VOUT_SET, 16'h0B00);
    ref_is(11'h2FF);
    chk({15'h0000, status_flags[0]}, 16'h0000);
    u_host.wr(CMD_VOUT_SET, 16'h0200);
    ref_is(11'h0BF);
    chk({15'h0000, status_flags[0]}, 16'h0001);
    u_host.wr(CMD_SCALE, 16'h0200);
    u_host.wr(CMD_TRIM, 16'h0000);
    u_host.wr(CMD_MARGIN_HI, 16'h0040);
    u_host.wr(CMD_OPERATION, 16'h0020);
    ref_is(11'h21F);
    u_host.wr(CMD_MARGIN_LO, 16'hFF00);
    u_host.rd(CMD_MARGIN_LO, d);
    chk(d, 16'hFFC0);
    u_host.wr(CMD_OPERATION, 16'h0030);
    ref_is(11'h1DF);
    u_host.wr(CMD_OPERATION, 16'h0000);
  endtask
  task automatic t_telemetry();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      sense_valid = 1'b1;
      remote_sense_output = 16'h0100 + 16'(i);
    end
    @(posedge clk);
    #1;
    sense_valid = 1'b0;
    remote_sense_output = 16'hFFFF;
    repeat (3) @(posedge clk);
    u_host.rd(CMD_READ_VOUT, d);
    chk(d, 16'h0103);
  endtask
  task automatic t_gating();
    u_host.wr(CMD_ON_OFF, 16'h000E);
    u_host.wr(CMD_OPERATION, 16'h0080);
    idle(6);
    chk({15'h0000, regulate_en}, 16'h0000);
    control_pin = 1'b1;
    wait_reg(1'b1, 8);
    u_host.wr(CMD_OPERATION, 16'h0000);
    wait_reg(1'b0, 8);
    u_host.wr(CMD_ON_OFF, 16'h0004);
    wait_reg(1'b0, 8);
    control_pin = 1'b0;
    wait_reg(1'b1, 8);
    u_host.wr(CMD_ON_OFF, 16'h0008);
    wait_reg(1'b0, 8);
  endtask
  task automatic t_delay();
    u_host.wr(CMD_TON, 16'h00C8);
    u_host.rd(CMD_TON, d);
    chk(d, 16'h0064);
    u_host.wr(CMD_TON, 16'h0002);
    u_host.wr(CMD_TOFF, 16'h0001);
    u_host.wr(CMD_OPERATION, 16'h0080);
    idle(5);
    u_host.wr(CMD_OPERATION, 16'h0000);
    idle(60);
    chk({15'h0000, regulate_en}, 16'h0000);
    u_host.wr(CMD_OPERATION, 16'h0080);
    wait_reg(1'b1, 200);
    if (n < 2 * MS - 2 || n > 2 * MS + 4) chk(16'(n), 16'(2 * MS));
    u_host.wr(CMD_OPERATION, 16'h0000);
    wait_reg(1'b0, 200);
    if (n < MS - 2 || n > MS + 4) chk(16'(n), 16'(MS));
    u_host.wr(CMD_TON, 16'h0000);
    u_host.wr(CMD_TOFF, 16'h0000);
  endtask
  task automatic t_lockout();
    u_host.wr(CMD_INPUT_TURN_ON_THRESHOLD, 16'h0040);
    u_host.rd(CMD_INPUT_TURN_ON_THRESHOLD, d);
    chk(d, 16'h001F);
    u_host.wr(CMD_INPUT_TURN_OFF_THRESHOLD, 16'h0002);
    u_host.rd(CMD_INPUT_TURN_OFF_THRESHOLD, d);
    chk(d, 16'h0010);
    u_host.wr(CMD_INPUT_TURN_ON_THRESHOLD, 16'h0014);
    u_host.wr(CMD_INPUT_TURN_OFF_THRESHOLD, 16'h0011);
    vin_meas = 16'h0010;
    idle(2);
    vin_meas = 16'h0012;
    u_host.wr(CMD_ON_OFF, 16'h0000);
    wait_reg(1'b0, 8);
    idle(6);
    chk({15'h0000, regulate_en}, 16'h0000);
    vin_meas = 16'h0014;
    wait_reg(1'b1, 8);
    vin_meas = 16'h0011;
    idle(6);
    chk({15'h0000, regulate_en}, 16'h0001);
    vin_meas = 16'h0010;
    wait_reg(1'b0, 8);
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    control_pin = 1'b0;
    sense_valid = 1'b0;
    remote_sense_output = 16'h0000;
    vin_meas = 16'h0018;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_vout();
    t_telemetry();
    t_gating();
    t_delay();
    t_lockout();
    wrap_up();
  end
endmodule
`default_nettype wire
